// ### bench/line_lock_status_and_pixel_clock_tb_top.sv
// self-checking bench for the line-lock status and pixel clock block
module line_lock_status_and_pixel_clock_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic                  pclk;
  logic                  presetn;
  llc_pkg::llc_apb_req_t req;
  llc_pkg::llc_apb_rsp_t rsp;
  logic [3:0]            osc;
  logic                  sync_n;
  logic                  pcmp;
  logic                  pix;
  logic                  plim;
  logic                  unlock;
  logic                  lock;
  int                    num_errors;
  int                    samples_checked;
  int                    cyc;
  int                    seed;
  int                    m_tab[4] = '{1, 3, 2, 0};

  llc_top dut_u (
    .pclk                   (pclk),
    .presetn                (presetn),
    .apb_req                (req),
    .apb_rsp                (rsp),
    .oscillator_input       (osc),
    .composite_sync_n       (sync_n),
    .phase_compare_out      (pcmp),
    .pixel_clock            (pix),
    .phase_limit_active     (plim),
    .continuous_unlock_flag (unlock),
    .lock_error_flag        (lock)
  );

  llc_partner src_u (
    .oscillator_input  (osc),
    .composite_sync_n  (sync_n),
    .phase_compare_out (pcmp)
  );

  always #20 pclk = ~pclk;

  task automatic summarize();
    begin
      $display("checks %0d errors %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0)
        $display("NO MISMATCHES");
      else
        $display("MISMATCHES SEEN");
      $finish;
    end
  endtask : summarize

  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      num_errors++;
      $display("[ERR] %0t timeout", $time);
      summarize();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    begin
      samples_checked++;
      if (got !== exp)
      begin
        num_errors++;
        $display("[ERR] %0t %s got %0h exp %0h", $time, m, got, exp);
      end
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd,
                     output logic err);
    int n;
    begin
      n = 0;
      @(posedge pclk);
      req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: wd};
      @(posedge pclk);
      req.penable <= 1'b1;
      do
      begin
        @(posedge pclk);
        n++;
      end
      while (rsp.pready !== 1'b1);
      chk(n, 32'h1, "wait states");
      rd = rsp.prdata;
      err = rsp.pslverr;
      req <= '0;
    end
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    begin
      apb(1'b1, a, d, r, e);
    end
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input logic eerr);
    logic [31:0] r;
    logic        e;
    begin
      apb(1'b0, a, 32'h0, r, e);
      chk(r, exp, "prdata");
      chk({31'h0, e}, {31'h0, eerr}, "pslverr");
    end
  endtask : rdc

  task automatic watch(input int n, output int tg);
    logic p;
    begin
      tg = 0;
      p = pix;
      repeat (n)
      begin
        @(posedge pclk);
        if (pix !== p)
          tg++;
        p = pix;
      end
    end
  endtask : watch

  // length in cycles of the next complete run of pixel clock at level lvl
  task automatic runlen(input logic lvl, output int c);
    begin
      c = 0;
      while (pix !== ~lvl && c < 200)
      begin
        @(posedge pclk);
        c++;
      end
      while (pix !== lvl && c < 400)
      begin
        @(posedge pclk);
        c++;
      end
      c = 0;
      while (pix === lvl && c < 200)
      begin
        @(posedge pclk);
        c++;
      end
    end
  endtask : runlen

  function automatic logic exp_lim(input logic p, input logic o, input logic u);
    return p & (~o | u);
  endfunction : exp_lim

  // random limit controls in mode 11; ends with limiting disabled
  task automatic lim(input logic u);
    logic [31:0] r;
    begin
      repeat (6)
      begin
        r = $random(seed);
        wr(llc_pkg::ADDR_CTRL, 32'h30 | {24'h0, r[1:0], 6'h0});
        repeat (4) @(posedge pclk);
        chk({31'h0, plim}, {31'h0, exp_lim(r[0], r[1], u)}, "limit");
      end
      wr(llc_pkg::ADDR_CTRL, 32'h30);
    end
  endtask : lim

  initial
  begin
    int t;
    int lo;
    int hi;
    int m;
    pclk = 1'b0;
    presetn = 1'b0;
    req = '0;
    num_errors = 0;
    samples_checked = 0;
    cyc = 0;
    seed = 32'hB4CBB10B;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rdc(llc_pkg::ADDR_LINE_LEN, 32'hFFF, 1'b0);
    rdc(llc_pkg::ADDR_OSC_CNT, 32'h202, 1'b0);
    rdc(llc_pkg::ADDR_STATUS, 32'h20, 1'b0);
    rdc(8'h14, 32'h0, 1'b1);
    wr(llc_pkg::ADDR_STATUS, 32'h0);
    rdc(llc_pkg::ADDR_STATUS, 32'h20, 1'b0);
    $display("test registers done");
    // upper half of the loop repeats each input with both pairs differential
    for (int s = 0; s < 8; s++)
    begin
      wr(llc_pkg::ADDR_CTRL, 32'h20 | (s & 3) | ((s & 4) != 0 ? 32'hC : 32'h0));
      watch(64, t);
      chk({31'h0, t > 0}, 32'h1, "osc select");
    end
    wr(llc_pkg::ADDR_CTRL, 32'h20);
    repeat (3)
    begin
      lo = 1 + ($random(seed) & 3);
      hi = 1 + ($random(seed) & 3);
      wr(llc_pkg::ADDR_OSC_CNT, (hi << 8) | lo);
      runlen(1'b1, t);
      chk(t, hi * 4, "high run");
      runlen(1'b0, t);
      chk(t, lo * 4, "low run");
    end
    $display("test pixel clock done");
    wr(llc_pkg::ADDR_OSC_CNT, 32'h101);
    wr(llc_pkg::ADDR_LOCK_CFG, 32'h201);
    wr(llc_pkg::ADDR_CTRL, 32'h130);
    rdc(llc_pkg::ADDR_STATUS, 32'h21, 1'b0);
    repeat (3) src_u.line(100 + ($random(seed) & 127), 8000);
    chk({31'h0, unlock}, 32'h0, "unlock");
    rdc(llc_pkg::ADDR_STATUS, 32'h01, 1'b0);
    lim(1'b0);
    src_u.line(3000, 8000);
    src_u.line(100, 8000);
    chk({31'h0, lock}, 32'h0, "lock");
    chk({31'h0, unlock}, 32'h1, "unlock");
    wr(llc_pkg::ADDR_STATUS, 32'h0);
    rdc(llc_pkg::ADDR_STATUS, 32'h20, 1'b0);
    lim(1'b1);
    $display("test lock done");
    wr(llc_pkg::ADDR_LINE_LEN, 32'h5);
    foreach (m_tab[k])
    begin
      m = m_tab[k];
      wr(llc_pkg::ADDR_CTRL, m << 4);
      src_u.line(100, 2000);
      watch(64, t);
      chk({31'h0, t == 0}, {31'h0, m == 1}, "halt");
      if (m == 1)
        chk({31'h0, pix}, 32'h1, "halt level");
    end
    $display("test counter modes done");
    summarize();
  end

endmodule : line_lock_status_and_pixel_clock_tb_top

// ### bench/llc_partner.sv
// partner model: video source with oscillators, composite sync and phase comparator
module llc_partner (
  output logic [3:0] oscillator_input,
  output logic       composite_sync_n,
  output logic       phase_compare_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic osc_a;
  logic osc_b;
  initial
  begin
    osc_a = 1'b0;
    osc_b = 1'b0;
    composite_sync_n = 1'b1;
    phase_compare_out = 1'b0;
  end
  always #160 osc_a = ~osc_a;
  always #200 osc_b = ~osc_b;
  // true legs on even pins, complements on odd pins
  assign oscillator_input = {~osc_b, osc_b, ~osc_a, osc_a};
  // one scan line: sync fall, sync pulse, comparator active for act_ns, then rest of line
  task automatic line(input int act_ns, input int len_ns);
    begin
      composite_sync_n <= 1'b0;
      #2000;
      composite_sync_n <= 1'b1;
      phase_compare_out <= 1'b1;
      #(act_ns);
      phase_compare_out <= 1'b0;
      #(len_ns);
    end
  endtask : line
endmodule : llc_partner

// ### core/llc_sync.sv
// three-stage pin synchroniser; output follows once stages two and three agree
module llc_sync #(
  parameter int W = 1
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] pin,
  output logic      [W-1:0] level
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] lvl;
  } llc_sync_state_t;
  llc_sync_state_t q;
  llc_sync_state_t d;
  always_comb
  begin
    d    = q;
    d.s1 = pin;
    d.s2 = q.s1;
    d.s3 = q.s2;
    for (int i = 0; i < W; i++)
    begin
      if (q.s2[i] == q.s3[i])
      begin
        d.lvl[i] = q.s3[i];
      end
    end
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      q <= '0;
    end
    else
    begin
      q <= d;
    end
  end
  assign level = q.lvl;
endmodule : llc_sync

// ### core/llc_top.sv
// line-lock status flags and oscillator-divided pixel clock with horizontal counter
// Functional notes
// - per line, comparator active time above pixel threshold clears the lock flag.
// - software rearms lock flag by writing the rearm bit; device clears it.
// - enough consecutive good lines clear the continuous-unlock flag.
// - any bad line sets the continuous-unlock flag.
// - continuous-unlock flag ignores software writes.
// - phase-limit enable plus lock override lets continuous-unlock decide limiting.
// - active time comes straight from the phase comparator output.
// - status read shows the live continuous-unlock flag.
// - four oscillator inputs, one selected, pairs single-ended or differential.
// - pixel clock low and high last programmed oscillator half-periods each.
// - each sync falling edge restarts the pixel clock cycle.
// - mode 01 halts counter and clock high at line length until sync.
// - mode 01 sync edge before line length clears counter, clock keeps running.
// - mode 11 counter wraps at line length, clock runs on.
// - mode 11 sync edge clears counter, which then counts on.
// - mode 10 counter resets only at line length.
// - twelve-bit counter advances on pixel clock rise, not readable.
//
// The APB interface to the registers and the register addresses were decided locally.
module llc_top (
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire llc_pkg::llc_apb_req_t apb_req,
  output llc_pkg::llc_apb_rsp_t      apb_rsp,
  input  wire logic [3:0]            oscillator_input,
  input  wire logic                  composite_sync_n,
  input  wire logic                  phase_compare_out,
  output logic                       pixel_clock,
  output logic                       phase_limit_active,
  output logic                       continuous_unlock_flag,
  output logic                       lock_error_flag
);
  llc_pkg::llc_state_t q;
  llc_pkg::llc_state_t d;
  logic [3:0]  osc_s;
  logic        sync_s;
  logic        pc_s;
  logic        osc_now;
  logic        osc_edge;
  logic        sync_fall;
  logic        setup;
  logic        wr_en;
  logic        bad_line;
  logic [8:0]  good_nx;
  logic [7:0]  phase_len;
  logic        pix_rise;
  logic        mode_halt;
  logic        mode_clr;

  llc_sync #(.W(6)) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .pin     ({phase_compare_out, composite_sync_n, oscillator_input}),
    .level   ({pc_s, sync_s, osc_s})
  );

  // selected oscillator level; a differential pair follows its true leg while legs differ
  always_comb
  begin
    osc_now = osc_s[q.osc_sel];
    if (q.diff_en[q.osc_sel[1]])
    begin
      osc_now = (osc_s[{q.osc_sel[1], 1'b0}] != osc_s[{q.osc_sel[1], 1'b1}]) ?
                osc_s[{q.osc_sel[1], 1'b0}] : q.osc_lvl;
    end
  end

  assign osc_edge  = osc_now != q.osc_lvl;
  assign sync_fall = q.sync_lvl & ~sync_s;
  assign setup     = apb_req.psel & ~apb_req.penable;
  assign wr_en     = apb_req.psel & apb_req.penable & apb_req.pwrite & q.rsp.pready & ~q.rsp.pslverr;
  assign bad_line  = q.act_cnt > {1'b0, q.pix_thr};
  assign good_nx   = {1'b0, q.good_lines} + 9'h001;
  assign phase_len = (q.pc_state == llc_pkg::PC_LOW) ? q.osc_low : q.osc_high;
  assign mode_halt = q.cnt_mode == llc_pkg::MODE_HALT;
  assign mode_clr  = q.cnt_mode[0];
  assign pix_rise  = ~sync_fall & osc_edge & (q.pc_state == llc_pkg::PC_LOW) &
                     ({1'b0, q.half_cnt} + 9'h001 >= {1'b0, (phase_len == 8'h00) ? 8'h01 : phase_len});

  always_comb
  begin
    d          = q;
    d.osc_lvl  = osc_now;
    d.sync_lvl = sync_s;
    // bus slave: answer prepared in setup, zero-wait access
    d.rsp.pready  = setup;
    d.rsp.pslverr = 1'b0;
    d.rsp.prdata  = 32'h0000_0000;
    if (setup)
    begin
      unique case (apb_req.paddr)
        llc_pkg::ADDR_CTRL:
        begin
          d.rsp.prdata[llc_pkg::CTRL_OSC_SEL +: 2] = q.osc_sel;
          d.rsp.prdata[llc_pkg::CTRL_DIFF +: 2]    = q.diff_en;
          d.rsp.prdata[llc_pkg::CTRL_MODE +: 2]    = q.cnt_mode;
          d.rsp.prdata[llc_pkg::CTRL_PLEN]         = q.plen;
          d.rsp.prdata[llc_pkg::CTRL_LOVR]         = q.lovr;
        end
        llc_pkg::ADDR_LOCK_CFG:
        begin
          d.rsp.prdata[llc_pkg::CFG_PIX_THR +: 4]  = q.pix_thr;
          d.rsp.prdata[llc_pkg::CFG_LINE_THR +: 8] = q.line_thr;
        end
        llc_pkg::ADDR_OSC_CNT:
        begin
          d.rsp.prdata[llc_pkg::OSC_LOW_POS +: 8]  = q.osc_low;
          d.rsp.prdata[llc_pkg::OSC_HIGH_POS +: 8] = q.osc_high;
        end
        llc_pkg::ADDR_LINE_LEN:
        begin
          d.rsp.prdata[11:0] = q.line_len;
        end
        llc_pkg::ADDR_STATUS:
        begin
          d.rsp.prdata[llc_pkg::STAT_LOCK]   = q.lock_flag;
          d.rsp.prdata[llc_pkg::STAT_UNLOCK] = q.cu_flag;
        end
        default:
        begin
          d.rsp.pslverr = 1'b1;
        end
      endcase
    end
    if (wr_en)
    begin
      unique case (apb_req.paddr)
        llc_pkg::ADDR_CTRL:
        begin
          d.osc_sel  = apb_req.pwdata[llc_pkg::CTRL_OSC_SEL +: 2];
          d.diff_en  = apb_req.pwdata[llc_pkg::CTRL_DIFF +: 2];
          d.cnt_mode = apb_req.pwdata[llc_pkg::CTRL_MODE +: 2];
          d.plen     = apb_req.pwdata[llc_pkg::CTRL_PLEN];
          d.lovr     = apb_req.pwdata[llc_pkg::CTRL_LOVR];
          if (apb_req.pwdata[llc_pkg::CTRL_REARM])
          begin
            d.lock_flag = 1'b1;
          end
        end
        llc_pkg::ADDR_LOCK_CFG:
        begin
          d.pix_thr  = apb_req.pwdata[llc_pkg::CFG_PIX_THR +: 4];
          d.line_thr = apb_req.pwdata[llc_pkg::CFG_LINE_THR +: 8];
        end
        llc_pkg::ADDR_OSC_CNT:
        begin
          d.osc_low  = apb_req.pwdata[llc_pkg::OSC_LOW_POS +: 8];
          d.osc_high = apb_req.pwdata[llc_pkg::OSC_HIGH_POS +: 8];
        end
        llc_pkg::ADDR_LINE_LEN:
        begin
          d.line_len = apb_req.pwdata[11:0];
        end
        default:
        begin
          d.line_len = q.line_len; // status is read-only
        end
      endcase
    end
    // comparator active time, in pixel clocks, per line
    if (pc_s && pix_rise && q.act_cnt != 5'h1F)
    begin
      d.act_cnt = q.act_cnt + 5'h01;
    end
    if (sync_fall)
    begin
      d.act_cnt = 5'h00;
      if (bad_line)
      begin
        d.lock_flag  = 1'b0;
        d.cu_flag    = 1'b1;
        d.good_lines = 8'h00;
      end
      else if (good_nx >= {1'b0, q.line_thr})
      begin
        d.cu_flag = 1'b0;
      end
      else
      begin
        d.good_lines = good_nx[7:0];
      end
    end
    d.plim = q.plen & (~q.lovr | q.cu_flag);
    // pixel clock divider and horizontal counter
    if (sync_fall)
    begin
      d.pc_state = llc_pkg::PC_HIGH;
      d.pix_clk  = 1'b1;
      d.half_cnt = 8'h00;
      if (mode_clr)
      begin
        d.line_length_count = 12'h000;
      end
    end
    else
    begin
      unique case (q.pc_state)
        llc_pkg::PC_HALT:
        begin
          if (!mode_halt)
          begin
            d.pc_state = llc_pkg::PC_HIGH;
          end
        end
        llc_pkg::PC_LOW,
        llc_pkg::PC_HIGH:
        begin
          if (osc_edge)
          begin
            d.half_cnt = q.half_cnt + 8'h01;
            if ({1'b0, q.half_cnt} + 9'h001 >= {1'b0, (phase_len == 8'h00) ? 8'h01 : phase_len})
            begin
              d.half_cnt = 8'h00;
              d.pix_clk  = ~q.pix_clk;
              d.pc_state = (q.pc_state == llc_pkg::PC_LOW) ? llc_pkg::PC_HIGH : llc_pkg::PC_LOW;
            end
          end
          if (pix_rise)
          begin
            if (q.line_length_count == q.line_len)
            begin
              if (mode_halt)
              begin
                d.pc_state = llc_pkg::PC_HALT;
              end
              else
              begin
                d.line_length_count = 12'h000;
              end
            end
            else
            begin
              d.line_length_count = q.line_length_count + 12'h001;
            end
          end
        end
        default:
        begin
          d.pc_state = llc_pkg::PC_HIGH;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      q          <= '0;
      q.osc_low  <= llc_pkg::RST_OSC_COUNT;
      q.osc_high <= llc_pkg::RST_OSC_COUNT;
      q.line_len <= llc_pkg::RST_LINE_LEN;
      q.cu_flag  <= 1'b1;
      q.pc_state <= llc_pkg::PC_LOW;
    end
    else
    begin
      q <= d;
    end
  end

  assign apb_rsp                = q.rsp;
  assign pixel_clock            = q.pix_clk;
  assign phase_limit_active     = q.plim;
  assign continuous_unlock_flag = q.cu_flag;
  assign lock_error_flag        = q.lock_flag;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  property p_rearm;
    wr_en && apb_req.paddr == llc_pkg::ADDR_CTRL && apb_req.pwdata[llc_pkg::CTRL_REARM] && !sync_fall
      |=> q.lock_flag;
  endproperty
  a_rearm: assert property (p_rearm) else $error("rearm write did not set lock flag");

  property p_bad_clears_lock;
    sync_fall && bad_line |=> !q.lock_flag && q.cu_flag;
  endproperty
  a_bad_clears_lock: assert property (p_bad_clears_lock) else $error("bad line kept lock flags");

  property p_bad_sets_unlock;
    sync_fall && bad_line |=> q.cu_flag ##1 (q.cu_flag || $past(sync_fall));
  endproperty
  a_bad_sets_unlock: assert property (p_bad_sets_unlock) else $error("unlock flag not set");

  property p_unlock_only_per_line;
    !sync_fall |=> $stable(q.cu_flag);
  endproperty
  a_unlock_only_per_line: assert property (p_unlock_only_per_line) else $error("unlock flag moved");

  property p_good_lines_clear;
    sync_fall && !bad_line && good_nx >= {1'b0, q.line_thr} |=> !q.cu_flag;
  endproperty
  a_good_lines_clear: assert property (p_good_lines_clear) else $error("unlock flag not cleared");

  property p_auto_limit;
    q.plen && q.lovr |=> phase_limit_active == $past(q.cu_flag);
  endproperty
  a_auto_limit: assert property (p_auto_limit) else $error("phase limit not from unlock flag");

  property p_status_live;
    setup && apb_req.paddr == llc_pkg::ADDR_STATUS |=> apb_rsp.pready && apb_rsp.prdata[5] == $past(q.cu_flag);
  endproperty
  a_status_live: assert property (p_status_live) else $error("status read stale");

  property p_restart;
    sync_fall |=> pixel_clock && q.half_cnt == 8'h00;
  endproperty
  a_restart: assert property (p_restart) else $error("pixel clock not restarted");

  property p_halt_hold;
    mode_halt && q.pc_state == llc_pkg::PC_HALT && !sync_fall |=> pixel_clock && $stable(q.line_length_count);
  endproperty
  a_halt_hold: assert property (p_halt_hold) else $error("halted counter moved");

  property p_sync_clears;
    sync_fall && mode_clr |=> q.line_length_count == 12'h000;
  endproperty
  a_sync_clears: assert property (p_sync_clears) else $error("sync did not clear counter");

  property p_wrap;
    pix_rise && !mode_halt && q.line_length_count == q.line_len |=> q.line_length_count == 12'h000;
  endproperty
  a_wrap: assert property (p_wrap) else $error("counter did not wrap");

  property p_free_ignores_sync;
    sync_fall && !mode_clr |=> $stable(q.line_length_count);
  endproperty
  a_free_ignores_sync: assert property (p_free_ignores_sync) else $error("sync cleared counter");

  c_halt: cover property (mode_halt && q.pc_state == llc_pkg::PC_HALT ##[1:100] sync_fall);
  c_lock: cover property (q.cu_flag ##[1:1000] !q.cu_flag);
  c_wrap: cover property (pix_rise && q.cnt_mode == llc_pkg::MODE_WRAP && q.line_length_count == q.line_len);
  c_rearm: cover property (wr_en && apb_req.paddr == llc_pkg::ADDR_CTRL && apb_req.pwdata[llc_pkg::CTRL_REARM]);
  c_bad_line: cover property (sync_fall && bad_line);
endmodule : llc_top

// ### inc/llc_pkg.sv
// package: register map, field layout and types of the line-lock status and pixel clock block
package llc_pkg;
  localparam logic [7:0] ADDR_CTRL     = 8'h00;
  localparam logic [7:0] ADDR_LOCK_CFG = 8'h04;
  localparam logic [7:0] ADDR_OSC_CNT  = 8'h08;
  localparam logic [7:0] ADDR_LINE_LEN = 8'h0C;
  localparam logic [7:0] ADDR_STATUS   = 8'h10;
  localparam int CTRL_OSC_SEL   = 0;
  localparam int CTRL_DIFF      = 2;
  localparam int CTRL_MODE      = 4;
  localparam int CTRL_PLEN      = 6;
  localparam int CTRL_LOVR      = 7;
  localparam int CTRL_REARM     = 8;
  localparam int CFG_PIX_THR    = 0;
  localparam int CFG_LINE_THR   = 8;
  localparam int OSC_LOW_POS    = 0;
  localparam int OSC_HIGH_POS   = 8;
  localparam int STAT_LOCK      = 0;
  localparam int STAT_UNLOCK    = 5;
  localparam logic [7:0] RST_OSC_COUNT = 8'h02;
  localparam logic [11:0] RST_LINE_LEN = 12'hFFF;
  localparam logic [1:0] MODE_RSVD = 2'h0;
  localparam logic [1:0] MODE_HALT = 2'h1;
  localparam logic [1:0] MODE_FREE = 2'h2;
  localparam logic [1:0] MODE_WRAP = 2'h3;
  typedef enum logic [2:0] {
    PC_LOW  = 3'b001,
    PC_HIGH = 3'b010,
    PC_HALT = 3'b100
  } llc_pc_state_t;
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } llc_apb_req_t;
  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } llc_apb_rsp_t;
  typedef struct packed {
    llc_apb_rsp_t  rsp;
    logic [1:0]    osc_sel;
    logic [1:0]    diff_en;
    logic [1:0]    cnt_mode;
    logic          plen;
    logic          lovr;
    logic [3:0]    pix_thr;
    logic [7:0]    line_thr;
    logic [7:0]    osc_low;
    logic [7:0]    osc_high;
    logic [11:0]   line_len;
    logic          lock_flag;
    logic          cu_flag;
    logic [7:0]    good_lines;
    logic [4:0]    act_cnt;
    llc_pc_state_t pc_state;
    logic          pix_clk;
    logic [7:0]    half_cnt;
    logic [11:0]   line_length_count;
    logic          osc_lvl;
    logic          sync_lvl;
    logic          plim;
  } llc_state_t;
endpackage : llc_pkg
